// ---- logic/fmsp_centroid.sv ----
// charge centroid of one small strip chamber plane
// assumes one band of five strip charges per plane and crossing, on clk_sys
`include "fmsp_regs.svh"

module fmsp_centroid (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic frame_start,
    input wire logic in_valid,
    input wire logic [9:0] in_base,
    input wire logic [29:0] in_charge,
    input wire logic [5:0] thresh,
    output logic hit_q,
    output logic [15:0] pos_q
);
    logic [8:0] q_sum;
    logic [9:0] q_wsum;
    logic [12:0] offset;
    logic [5:0] q;

    // threshold the band, then weigh strip index by charge
    always_comb begin
        q_sum = 9'h000;
        q_wsum = 10'h000;
        q = 6'h00;
        for (int k = 0; k < `FMSP_BAND; k++) begin
            q = in_charge[k*6 +: 6];
            if (q >= thresh && q != 6'h00) begin
                q_sum = q_sum + {3'b000, q};
                q_wsum = q_wsum + 10'(q * k);
            end
        end
        offset = (q_sum == 9'h000) ? 13'h0000 : 13'({q_wsum, 3'b000} / {4'h0, q_sum});
    end

    // store one centroid per crossing, eighth-strip units
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hit_q <= 1'b0;
            pos_q <= 16'h0000;
        end else if (in_valid && q_sum != 9'h000) begin
            hit_q <= 1'b1;
            pos_q <= {3'b000, in_base, 3'b000} + {3'b000, offset};
        end else if (frame_start) begin
            hit_q <= 1'b0;
        end
    end
endmodule

// ---- logic/fmsp_first_hit.sv ----
// earliest-hit finder for one 64-strip group of the mesh strip chamber
// assumes hit reports arrive on clk_sys and frame_start opens each crossing
`include "fmsp_regs.svh"

module fmsp_first_hit #(
    parameter int GROUP = 0
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic frame_start,
    input wire logic hit_valid,
    input wire logic [5:0] hit_strip,
    input wire logic [4:0] hit_time,
    output logic found_q,
    output logic [11:0] addr_q,
    output logic [4:0] time_q
);
    localparam logic [11:0] BASE = 12'(GROUP * `FMSP_GROUP_STRIPS);

    logic earlier;

    // strict compare: on equal times the first report stays
    assign earlier = !found_q || (hit_time < time_q);

    // keep the earliest report of the crossing, restart on a new one
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            found_q <= 1'b0;
            addr_q <= 12'h000;
            time_q <= 5'h00;
        end else if (frame_start) begin
            found_q <= hit_valid;
            addr_q <= BASE + {6'h00, hit_strip};
            time_q <= hit_time;
        end else if (hit_valid && earlier) begin
            found_q <= 1'b1;
            addr_q <= BASE + {6'h00, hit_strip};
            time_q <= hit_time;
        end
    end
endmodule

// ---- logic/fmsp_pkg.sv ----
// types of the forward muon segment processor
// assumes fmsp_regs.svh supplies the figures; this holds types only
package fmsp_pkg;
    // frame tracking after reset
    typedef enum logic [1:0] {
        FMSP_WAIT = 2'b00,
        FMSP_FILL = 2'b01,
        FMSP_RUN = 2'b10
    } fmsp_state_t;

    typedef logic [15:0] fmsp_pos_t;
    typedef logic [27:0] fmsp_word_t;
endpackage

// ---- logic/fmsp_regs.svh ----
// constants of the forward muon segment processor: sizes, word fields, limits
// assumes inclusion by every design file that needs a figure of the block
`ifndef FMSP_REGS_SVH
`define FMSP_REGS_SVH

// link, plane and tower counts, strips per group and per band
`define FMSP_MM_LINKS 36
`define FMSP_SS_LINKS 36
`define FMSP_OUT_LINKS 12
`define FMSP_TOWERS 4
`define FMSP_PLANES 16
`define FMSP_MM_PLANES 8
`define FMSP_GROUP_STRIPS 64
`define FMSP_BAND 5

// segment word fields, msb first: eta, phi, deflection, monitor
`define FMSP_WORD_BITS 28
`define FMSP_ETA_LSB 14
`define FMSP_PHI_LSB 6
`define FMSP_DTH_LSB 1
`define FMSP_MON_BIT 0

// field scaling: deflection 1 mrad/lsb, phi 15 mrad/lsb, eta 0.0001/lsb
`define FMSP_DTH_MRAD_PER_LSB 1
`define FMSP_PHI_MRAD_PER_LSB 15
`define FMSP_ETA_LSB_PER_UNIT 10000
`define FMSP_DTH_LIMIT 15
`define FMSP_PNT_SHIFT 8
`define FMSP_LEGACY_MIN 3

// reset values of the configuration pins
`define FMSP_CFG_RESET 12'h000

`endif

// ---- logic/fmsp_top.sv ----
// forward muon segment processor for one azimuthal sector
// assumes all input links and the timing stream are already on clk_sys
`include "fmsp_regs.svh"

module fmsp_top
    import fmsp_pkg::*;
#(
    parameter int MM_LINKS = `FMSP_MM_LINKS,
    parameter int SS_LINKS = `FMSP_SS_LINKS,
    parameter int OUT_LINKS = `FMSP_OUT_LINKS,
    parameter int PNT_SHIFT = `FMSP_PNT_SHIFT,
    parameter logic [3:0] SECTOR = 4'h0
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic tcs_bc_start,
    input wire logic tcs_monitor,
    input wire logic cfg_legacy,
    input wire logic [4:0] cfg_min_planes,
    input wire logic [5:0] cfg_ss_thresh,
    input wire logic [MM_LINKS-1:0] mm_valid,
    input wire logic [MM_LINKS*6-1:0] mm_strip,
    input wire logic [MM_LINKS*5-1:0] mm_time,
    input wire logic [SS_LINKS-1:0] ss_valid,
    input wire logic [SS_LINKS*3-1:0] ss_plane,
    input wire logic [SS_LINKS*10-1:0] ss_base,
    input wire logic [SS_LINKS*30-1:0] ss_charge,
    input wire logic [`FMSP_TOWERS-1:0] ss_tower_valid,
    input wire logic [`FMSP_TOWERS*8-1:0] ss_tower_phi,
    output logic [OUT_LINKS-1:0] seg_valid_q,
    output logic [OUT_LINKS*`FMSP_WORD_BITS-1:0] seg_word_q,
    output logic mon_valid_q,
    output logic [31:0] mon_word_q
);
    localparam int NP = `FMSP_PLANES;
    localparam int MP = `FMSP_MM_PLANES;

    // sum of hits in one quadruplet
    function automatic logic [2:0] fmsp_count4(input logic [3:0] h);
        fmsp_count4 = {2'b00, h[0]} + {2'b00, h[1]} + {2'b00, h[2]} + {2'b00, h[3]};
    endfunction

    // mean of a sum of plane positions
    function automatic fmsp_pos_t fmsp_mean(input logic [19:0] s, input logic [4:0] n);
        fmsp_mean = (n == 5'h00) ? 16'h0000 : 16'(s / {15'h0000, n});
    endfunction

    // downstream board whose sector holds this phi
    function automatic logic [3:0] fmsp_link_of(input logic [7:0] phi);
        logic [11:0] prod;
        prod = 12'({4'h0, phi} * OUT_LINKS);
        fmsp_link_of = prod[11:8];
    endfunction

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [11:0] cfg_meta_q;
    logic [11:0] cfg_q;
    logic cfg_legacy_s;
    logic [4:0] cfg_min_s;
    logic [5:0] cfg_thresh_s;
    fmsp_state_t state_q;
    logic frame_done;

    // reset: asynchronous assert, released through two flops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // configuration pins pass two flops
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_meta_q <= `FMSP_CFG_RESET;
            cfg_q <= `FMSP_CFG_RESET;
        end else begin
            cfg_meta_q <= {cfg_legacy, cfg_min_planes, cfg_ss_thresh};
            cfg_q <= cfg_meta_q;
        end
    end
    assign cfg_legacy_s = cfg_q[11];
    assign cfg_min_s = cfg_q[10:6];
    assign cfg_thresh_s = cfg_q[5:0];

    // crossing tracking: the partial crossing after reset is thrown away
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= FMSP_WAIT;
        end else if (tcs_bc_start) begin
            case (state_q)
                FMSP_WAIT: state_q <= FMSP_FILL;
                FMSP_FILL: state_q <= FMSP_RUN;
                FMSP_RUN: state_q <= FMSP_RUN;
                default: state_q <= FMSP_WAIT;
            endcase
        end
    end
    assign frame_done = tcs_bc_start && (state_q != FMSP_WAIT);

    // mesh chamber: one finder per link, each link one 64-strip group
    logic [MM_LINKS-1:0] mm_found;
    logic [11:0] mm_addr [MM_LINKS];
    logic [4:0] mm_tim [MM_LINKS];

    for (genvar i = 0; i < MM_LINKS; i++) begin : g_mm
        fmsp_first_hit #(
            .GROUP(i / MP)
        ) u_first_hit (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .frame_start(tcs_bc_start),
            .hit_valid(mm_valid[i]),
            .hit_strip(mm_strip[i*6 +: 6]),
            .hit_time(mm_time[i*5 +: 5]),
            .found_q(mm_found[i]),
            .addr_q(mm_addr[i]),
            .time_q(mm_tim[i])
        );
    end

    // per mesh plane, the group whose first hit came earliest
    logic [MP-1:0] mm_phit;
    logic [11:0] mm_ppos [MP];
    logic [4:0] mm_ptim [MP];
    always_comb begin
        for (int p = 0; p < MP; p++) begin
            mm_phit[p] = 1'b0;
            mm_ppos[p] = 12'h000;
            mm_ptim[p] = 5'h1F;
        end
        for (int i = 0; i < MM_LINKS; i++) begin
            if (mm_found[i] && (!mm_phit[i % MP] || mm_tim[i] < mm_ptim[i % MP])) begin
                mm_phit[i % MP] = 1'b1;
                mm_ppos[i % MP] = mm_addr[i];
                mm_ptim[i % MP] = mm_tim[i];
            end
        end
    end

    // small strip chamber: lowest valid link reporting each plane
    logic [MP-1:0] sel_v;
    logic [9:0] sel_base [MP];
    logic [29:0] sel_q [MP];
    always_comb begin
        for (int p = 0; p < MP; p++) begin
            sel_v[p] = 1'b0;
            sel_base[p] = 10'h000;
            sel_q[p] = 30'h00000000;
        end
        for (int i = SS_LINKS - 1; i >= 0; i--) begin
            if (ss_valid[i]) begin
                sel_v[ss_plane[i*3 +: 3]] = 1'b1;
                sel_base[ss_plane[i*3 +: 3]] = ss_base[i*10 +: 10];
                sel_q[ss_plane[i*3 +: 3]] = ss_charge[i*30 +: 30];
            end
        end
    end

    logic [MP-1:0] ss_hit;
    fmsp_pos_t ss_pos [MP];

    for (genvar p = 0; p < MP; p++) begin : g_ss
        fmsp_centroid u_centroid (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .frame_start(tcs_bc_start),
            .in_valid(sel_v[p]),
            .in_base(sel_base[p]),
            .in_charge(sel_q[p]),
            .thresh(cfg_thresh_s),
            .hit_q(ss_hit[p]),
            .pos_q(ss_pos[p])
        );
    end

    // pad towers: the first valid tower gives small strip azimuth
    logic tw_ok;
    logic [7:0] tw_phi;
    always_comb begin
        tw_ok = 1'b0;
        tw_phi = 8'h00;
        for (int t = `FMSP_TOWERS - 1; t >= 0; t--) begin
            if (ss_tower_valid[t]) begin
                tw_ok = 1'b1;
                tw_phi = ss_tower_phi[t*8 +: 8];
            end
        end
    end

    // one position per plane: mesh planes 0-7, small strip planes 8-15
    logic [NP-1:0] pl_hit;
    fmsp_pos_t pl_pos [NP];
    always_comb begin
        for (int p = 0; p < MP; p++) begin
            pl_hit[p] = mm_phit[p];
            pl_pos[p] = {1'b0, mm_ppos[p], 3'b000};
            pl_hit[p + MP] = ss_hit[p];
            pl_pos[p + MP] = ss_pos[p];
        end
    end

    // stage a: capture the finished crossing
    logic a_valid_q;
    logic [NP-1:0] a_hit_q;
    fmsp_pos_t a_pos_q [NP];
    logic a_tw_q;
    logic [7:0] a_twphi_q;
    logic a_mon_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            a_valid_q <= 1'b0;
            a_hit_q <= '0;
            a_tw_q <= 1'b0;
            a_twphi_q <= 8'h00;
            a_mon_q <= 1'b0;
            for (int p = 0; p < NP; p++) begin
                a_pos_q[p] <= 16'h0000;
            end
        end else begin
            a_valid_q <= frame_done;
            if (tcs_bc_start) begin
                a_hit_q <= pl_hit;
                a_tw_q <= tw_ok;
                a_twphi_q <= tw_phi;
                a_mon_q <= tcs_monitor;
                for (int p = 0; p < NP; p++) begin
                    a_pos_q[p] <= pl_pos[p];
                end
            end
        end
    end

    // stage b logic: coincidence, fit sums, azimuth
    logic [2:0] quad [4];
    logic [4:0] n_all;
    logic coinc;
    logic [19:0] s_all;
    logic [19:0] s_in;
    logic [19:0] s_out;
    logic [4:0] n_in;
    logic [4:0] n_out;
    logic [1:0] st_n;
    logic [8:0] st_sum;
    logic [15:0] st_d;
    logic [7:0] phi;
    logic [8:0] phi_avg;
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            quad[g] = fmsp_count4(a_hit_q[g*4 +: 4]);
        end
        n_all = {2'b00, quad[0]} + {2'b00, quad[1]} + {2'b00, quad[2]} + {2'b00, quad[3]};
        if (cfg_legacy_s) begin
            coinc = (quad[0] >= `FMSP_LEGACY_MIN) && (quad[1] >= `FMSP_LEGACY_MIN) &&
                    (quad[2] >= `FMSP_LEGACY_MIN) && (quad[3] >= `FMSP_LEGACY_MIN);
        end else begin
            coinc = (n_all != 5'h00) && (n_all >= cfg_min_s);
        end
        s_all = 20'h00000;
        s_in = 20'h00000;
        s_out = 20'h00000;
        n_in = 5'h00;
        n_out = 5'h00;
        for (int p = 0; p < NP; p++) begin
            if (a_hit_q[p]) begin
                s_all = s_all + {4'h0, a_pos_q[p]};
                if ((p % 8) < 4) begin
                    s_in = s_in + {4'h0, a_pos_q[p]};
                    n_in = n_in + 5'h01;
                end else begin
                    s_out = s_out + {4'h0, a_pos_q[p]};
                    n_out = n_out + 5'h01;
                end
            end
        end
        // stereo pairs of the middle mesh layers
        st_n = 2'b00;
        st_sum = 9'h000;
        st_d = 16'h0000;
        if (a_hit_q[2] && a_hit_q[3]) begin
            st_d = a_pos_q[2] - a_pos_q[3];
            st_sum = st_sum + {1'b0, st_d[11:4] + 8'h80};
            st_n = st_n + 2'b01;
        end
        if (a_hit_q[5] && a_hit_q[4]) begin
            st_d = a_pos_q[5] - a_pos_q[4];
            st_sum = st_sum + {1'b0, st_d[11:4] + 8'h80};
            st_n = st_n + 2'b01;
        end
        if (st_n == 2'b10) begin
            st_sum = {1'b0, st_sum[8:1]};
        end
        // combine pad-tower azimuth with mesh stereo azimuth
        phi_avg = {1'b0, a_twphi_q} + {1'b0, st_sum[7:0]};
        if (a_tw_q && st_n != 2'b00) begin
            phi = phi_avg[8:1];
        end else if (st_n != 2'b00) begin
            phi = st_sum[7:0];
        end else begin
            phi = a_twphi_q;
        end
    end

    // stage b registers
    logic b_valid_q;
    logic b_pass_q;
    logic [19:0] b_sall_q;
    logic [19:0] b_sin_q;
    logic [19:0] b_sout_q;
    logic [4:0] b_nall_q;
    logic [4:0] b_nin_q;
    logic [4:0] b_nout_q;
    logic [7:0] b_phi_q;
    logic b_mon_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            b_valid_q <= 1'b0;
            b_pass_q <= 1'b0;
            b_sall_q <= 20'h00000;
            b_sin_q <= 20'h00000;
            b_sout_q <= 20'h00000;
            b_nall_q <= 5'h00;
            b_nin_q <= 5'h00;
            b_nout_q <= 5'h00;
            b_phi_q <= 8'h00;
            b_mon_q <= 1'b0;
        end else begin
            b_valid_q <= a_valid_q;
            b_pass_q <= coinc;
            b_sall_q <= s_all;
            b_sin_q <= s_in;
            b_sout_q <= s_out;
            b_nall_q <= n_all;
            b_nin_q <= n_in;
            b_nout_q <= n_out;
            b_phi_q <= phi;
            b_mon_q <= a_mon_q;
        end
    end

    // stage c logic: fit result, pointing, word, board choice
    fmsp_pos_t m_all;
    fmsp_pos_t m_in;
    fmsp_pos_t m_out;
    logic [16:0] slope;
    logic [16:0] dth;
    logic point_ok;
    fmsp_word_t word;
    logic [3:0] link;
    always_comb begin
        m_all = fmsp_mean(b_sall_q, b_nall_q);
        m_in = fmsp_mean(b_sin_q, b_nin_q);
        m_out = fmsp_mean(b_sout_q, b_nout_q);
        slope = {1'b0, m_out} - {1'b0, m_in};
        dth = slope - {1'b0, m_all >> PNT_SHIFT};
        point_ok = (b_nin_q != 5'h00) && (b_nout_q != 5'h00) &&
                   ($signed(dth) <= `FMSP_DTH_LIMIT) && ($signed(dth) >= -`FMSP_DTH_LIMIT);
        word = '0;
        word[`FMSP_WORD_BITS-1:`FMSP_ETA_LSB] = m_all[15:2];
        word[`FMSP_ETA_LSB-1:`FMSP_PHI_LSB] = b_phi_q;
        word[`FMSP_PHI_LSB-1:`FMSP_DTH_LSB] = dth[4:0];
        word[`FMSP_MON_BIT] = b_mon_q;
        link = fmsp_link_of(b_phi_q);
    end

    // stage c registers: segment links, one word per crossing
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            seg_valid_q <= '0;
            seg_word_q <= '0;
        end else begin
            seg_valid_q <= '0;
            if (b_valid_q) begin
                for (int l = 0; l < OUT_LINKS; l++) begin
                    seg_word_q[l*`FMSP_WORD_BITS +: `FMSP_WORD_BITS] <= word;
                end
                if (b_pass_q && point_ok && int'(link) < OUT_LINKS) begin
                    seg_valid_q[link] <= 1'b1;
                end
            end
        end
    end

    // monitoring link: sector, segment total, crossing count
    logic [15:0] bc_cnt_q;
    logic [11:0] seg_cnt_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bc_cnt_q <= 16'h0000;
            seg_cnt_q <= 12'h000;
            mon_valid_q <= 1'b0;
            mon_word_q <= 32'h00000000;
        end else begin
            mon_valid_q <= b_valid_q;
            if (b_valid_q) begin
                bc_cnt_q <= bc_cnt_q + 16'h0001;
                if (b_pass_q && point_ok) begin
                    seg_cnt_q <= seg_cnt_q + 12'h001;
                end
                mon_word_q <= {SECTOR, seg_cnt_q, bc_cnt_q};
            end
        end
    end
endmodule

// ---- verification/fmsp_checker.sv ----
// checker of the segment and monitoring outputs of fmsp_top
// assumes a bind onto fmsp_top; sees only its ports
module fmsp_checker #(
    parameter int OUT_LINKS = 12
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic tcs_bc_start,
    input wire logic tcs_monitor,
    input wire logic [OUT_LINKS-1:0] seg_valid_q,
    input wire logic [OUT_LINKS*28-1:0] seg_word_q,
    input wire logic mon_valid_q,
    input wire logic [31:0] mon_word_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] xing_q;
    logic [11:0] pass_q;
    logic [7:0] phi;
    assign phi = seg_word_q[13:6];
    // crossings and passed segments seen so far
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            xing_q <= 16'h0000;
            pass_q <= 12'h000;
        end else if (mon_valid_q) begin
            xing_q <= xing_q + 16'h0001;
            pass_q <= pass_q + 12'(seg_valid_q != '0);
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    one_board_a: assert property ($onehot0(seg_valid_q))
        else $error("more than one board strobed");
    board_pick_a: assert property (seg_valid_q != '0 |-> seg_valid_q[(phi * 12) >> 8])
        else $error("board does not follow phi");
    valid_with_mon_a: assert property (seg_valid_q != '0 |-> mon_valid_q)
        else $error("segment outside a processed crossing");
    mon_latency_a: assert property (mon_valid_q |-> $past(tcs_bc_start, 3))
        else $error("crossing result not three cycles after start");
    slices_same_a: assert property (mon_valid_q |-> seg_word_q == {OUT_LINKS{seg_word_q[27:0]}})
        else $error("output slices differ");
    monitor_bit_a: assert property (seg_valid_q != '0 |-> seg_word_q[0] == $past(tcs_monitor, 3))
        else $error("monitor bit wrong");
    dtheta_range_a: assert property (seg_valid_q != '0 |-> seg_word_q[5:1] != 5'h10)
        else $error("deflection out of range");
    quiet_reset_a: assert property ($rose(reset_n) |-> (!mon_valid_q && seg_valid_q == '0) [*4])
        else $error("output right after reset");
    mon_count_a: assert property (mon_valid_q |-> mon_word_q[27:0] == {pass_q, xing_q})
        else $error("monitoring counts wrong");
endmodule

bind fmsp_top fmsp_checker #(.OUT_LINKS(OUT_LINKS)) u_chk (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tcs_bc_start(tcs_bc_start),
    .tcs_monitor(tcs_monitor),
    .seg_valid_q(seg_valid_q),
    .seg_word_q(seg_word_q),
    .mon_valid_q(mon_valid_q),
    .mon_word_q(mon_word_q)
);

// ---- verification/fmsp_seg_sink.sv ----
// downstream coincidence stage model: takes strobed segment words
// assumes the twelve segment links of fmsp_top on the same clock
module fmsp_seg_sink (
    input wire logic clk_sys,
    input wire logic [11:0] seg_valid,
    input wire logic [335:0] seg_word,
    output int got_cnt,
    output logic [27:0] last_word
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    assign got_cnt = cnt;
    // a word is taken only in its strobe cycle, from its own board slice
    always @(posedge clk_sys) begin
        for (int k = 0; k < 12; k++) begin
            if (seg_valid[k] === 1'b1) begin
                cnt <= cnt + 1;
                last_word <= seg_word[k*28+:28];
            end
        end
    end
endmodule

// ---- verification/fmsp_top_tb.sv ----
// bench of fmsp_top: crossings of mesh and small strip hits, scoreboarded
// assumes fmsp_pkg, the design files, the checker and the sink compiled ahead
module fmsp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, reset_n, tcs_bc_start, tcs_monitor, cfg_legacy;
    logic [4:0] cfg_min_planes;
    logic [5:0] cfg_ss_thresh;
    logic [35:0] mm_valid, ss_valid;
    logic [215:0] mm_strip;
    logic [179:0] mm_time;
    logic [107:0] ss_plane;
    logic [359:0] ss_base;
    logic [1079:0] ss_charge;
    logic [3:0] tw_valid;
    logic [31:0] tw_phi, mon_word_q;
    logic [11:0] seg_valid_q;
    logic [335:0] seg_word_q;
    logic mon_valid_q;
    logic [27:0] last_word, exp_last;
    logic [32:0] note;
    logic [32:0] q[$];
    int got_cnt, n_x, n_pass, error_cnt, n_tests;
    fmsp_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .tcs_bc_start(tcs_bc_start),
        .tcs_monitor(tcs_monitor), .cfg_legacy(cfg_legacy), .cfg_min_planes(cfg_min_planes),
        .cfg_ss_thresh(cfg_ss_thresh), .mm_valid(mm_valid), .mm_strip(mm_strip), .mm_time(mm_time),
        .ss_valid(ss_valid), .ss_plane(ss_plane), .ss_base(ss_base), .ss_charge(ss_charge),
        .ss_tower_valid(tw_valid), .ss_tower_phi(tw_phi), .seg_valid_q(seg_valid_q),
        .seg_word_q(seg_word_q), .mon_valid_q(mon_valid_q), .mon_word_q(mon_word_q));
    fmsp_seg_sink u_sink (.clk_sys(clk_sys), .seg_valid(seg_valid_q), .seg_word(seg_word_q),
        .got_cnt(got_cnt), .last_word(last_word));
    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic chk(string what, logic [35:0] e, logic [35:0] s);
        n_tests++;
        if (e !== s) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic setcfg(bit l, int mp, int th);
        @(negedge clk_sys);
        tcs_bc_start = 1'b0;
        cfg_legacy = l;
        cfg_min_planes = 5'(mp);
        cfg_ss_thresh = 6'(th);
        repeat (4) @(negedge clk_sys);
    endtask
    // one crossing: hits on inner and outer plane, a second mesh report on mesh crossings only, closing start
    task automatic frame(bit ss, int a, int b, int a2, int t2, logic [7:0] phi, bit mon);
        int pi, po, m, d;
        bit ok;
        @(negedge clk_sys);
        tcs_bc_start = 1'b0;
        if (ss) begin
            ss_valid = 36'h3;
            ss_plane[5:0] = 6'h20;
            ss_base[19:0] = {10'(b), 10'(a)};
            ss_charge[59:0] = {30'h00000104, 30'h00000104};
        end else begin
            mm_valid = 36'h81;
            mm_strip[5:0] = 6'(a);
            mm_strip[47:42] = 6'(b);
            mm_time[4:0] = 5'h05;
            mm_time[39:35] = 5'h05;
        end
        @(negedge clk_sys);
        ss_valid = '0;
        mm_valid = {35'h0, !ss};
        mm_strip[5:0] = 6'(a2);
        mm_time[4:0] = 5'(t2);
        @(negedge clk_sys);
        mm_valid = '0;
        tcs_bc_start = 1'b1;
        tcs_monitor = mon;
        tw_valid = 4'h6;
        tw_phi = {8'h00, ~phi, phi, 8'h5A};
        pi = ss ? a * 8 + 4 : ((t2 < 5) ? a2 : a) * 8;
        po = ss ? b * 8 + 4 : b * 8;
        m = (pi + po) / 2;
        d = po - pi - (m >> 8);
        ok = !cfg_legacy && cfg_min_planes <= 2 && !(ss && cfg_ss_thresh > 4) && d >= -15 && d <= 15;
        q.push_back({ok, 4'((phi * 12) >> 8), 14'(m >> 2), phi, 5'(d), mon});
    endtask
    // scoreboard: each processed crossing retires the oldest note
    always @(negedge clk_sys) begin
        if (mon_valid_q === 1'b1) begin
            if (q.size() == 0) begin
                chk("spare crossing", 0, 1);
            end else begin
                note = q.pop_front();
                chk("valid", note[32] ? 12'h001 << note[31:28] : 12'h000, seg_valid_q);
                if (note[32]) chk("word", note[27:0], seg_word_q[note[31:28]*28+:28]);
                chk("mon word", {4'h0, 12'(n_pass), 16'(n_x)}, mon_word_q);
                if (note[32]) exp_last = note[27:0];
                n_x++;
                n_pass += int'(note[32]);
            end
        end
    end
    // hang guard
    initial begin
        repeat (3000) @(negedge clk_sys);
        chk("timeout", 0, 1);
        final_report();
    end
    initial begin
        int ra, rb;
        {tcs_bc_start, tcs_monitor, mm_valid, ss_valid, mm_strip, mm_time} = '0;
        {ss_plane, ss_base, ss_charge, tw_valid, tw_phi} = '0;
        cfg_legacy = 1'b0;
        cfg_min_planes = 5'h02;
        cfg_ss_thresh = 6'h04;
        reset_n = 1'b0;
        void'($urandom(32));
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        tcs_bc_start = 1'b1;
        frame(0, 10, 10, 0, 9, 8'h80, 1);
        frame(0, 10, 11, 0, 9, 8'h15, 0);
        frame(0, 11, 10, 0, 9, 8'hFF, 1);
        frame(0, 40, 42, 0, 9, 8'h40, 0);
        frame(0, 10, 12, 0, 9, 8'h40, 0);
        frame(0, 30, 12, 12, 2, 8'h22, 1);
        frame(0, 12, 12, 50, 5, 8'hC3, 0);
        frame(1, 10, 10, 0, 9, 8'h90, 1);
        // random crossings of both kinds, deflection around the range edges
        for (int i = 0; i < 16; i++) begin
            ra = 8 + int'($urandom % 30);
            rb = ra + int'($urandom % 5) - 2;
            frame(bit'($urandom), ra, rb, 0, 9, 8'($urandom), bit'($urandom));
        end
        setcfg(0, 2, 5);
        frame(1, 10, 10, 0, 9, 8'h90, 0);
        setcfg(0, 3, 4);
        frame(0, 10, 10, 0, 9, 8'h90, 0);
        setcfg(1, 2, 4);
        frame(0, 10, 10, 0, 9, 8'h90, 0);
        setcfg(0, 0, 4);
        frame(0, 10, 10, 0, 9, 8'h90, 1);
        setcfg(0, 2, 4);
        for (int i = 0; i < 20 && q.size() > 0; i++) @(negedge clk_sys);
        chk("notes left", 0, q.size());
        chk("sink count", n_pass, got_cnt);
        chk("sink word", exp_last, last_word);
        final_report();
    end
endmodule
